// ===== core/pef_event_flags.sv
// Top: peripheral event flag register with Avalon-MM slave and interrupt
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Port B collision sets sticky flag bit 4
// R2 - Port A collision sets sticky flag bit 3
// R3 - Low-voltage detect sets sticky flag bit 2
// R4 - Timer C rollover sets sticky flag bit 1
// R5 - Timer C gate event sets flag bit 0
// R6 - Only software clears flags, never hardware
// R7 - Set beats same-cycle clear; no lost events
module pef_event_flags
  import pef_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic port_b_collision,
  input wire logic port_a_collision,
  input wire logic voltage_low,
  input wire logic timer_c_counter_rollover,
  input wire logic timer_c_gate_event,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // State and nets

  typedef struct packed {
    pef_bus_state_t bus;
    logic [7:0] mask;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
  } pef_top_state_t;

  pef_top_state_t state;
  pef_top_state_t next_state;

  logic [PEF_NUM_EVENTS-1:0] events;
  logic [PEF_NUM_EVENTS-1:0] clr;
  logic [PEF_NUM_EVENTS-1:0] flags;
  logic [7:0] flags_byte;
  logic take_write;
  logic take_read;
  logic any_request;
  logic lane0_write;
  logic hit_flags;
  logic hit_mask;
  logic hit_status;
  logic hit_raw;
  logic clear_hit;
  logic mask_hit;
  logic [7:0] mask_next;
  logic [7:0] raw_byte;
  logic [7:0] pending_byte;
  logic [31:0] read_word;
  logic irq_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Places the event bits in their register byte; unused bits read zero
  function automatic logic [7:0] pef_pad(input logic [PEF_NUM_EVENTS-1:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[PEF_NUM_EVENTS-1:0] = v;
    pef_pad = b & PEF_FLAG_IMPL;
  endfunction

  // Word address compare, shared by the read mux and the write decode
  function automatic logic pef_addr_is(input logic [1:0] addr, input logic [1:0] target);
    pef_addr_is = (addr == target);
  endfunction

  function automatic logic [31:0] pef_widen(input logic [7:0] b);
    pef_widen = {24'h000000, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Events and sticky flags
  // Levels, not edges: an event held high keeps setting its flag

  always_comb begin
    events = '0;
    events[PEF_BIT_COLB] = port_b_collision; // R1
    events[PEF_BIT_COLA] = port_a_collision; // R2
    events[PEF_BIT_VOLT] = voltage_low; // R3
    events[PEF_BIT_OVF] = timer_c_counter_rollover; // R4
    events[PEF_BIT_GATE] = timer_c_gate_event; // R5
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request decode

  // Access taken in the cycle waitrequest is low
  assign any_request = avs_read || avs_write;
  assign take_write = avs_write && (state.bus == PEF_BUS_ACK);
  assign take_read = avs_read && (state.bus == PEF_BUS_ACK);
  // Only byte lane 0 carries register bits; a write without it is dropped
  assign lane0_write = take_write && avs_byteenable[0];
  assign hit_flags = pef_addr_is(avs_address, PEF_ADDR_FLAGS);
  assign hit_mask = pef_addr_is(avs_address, PEF_ADDR_MASK);
  assign hit_status = pef_addr_is(avs_address, PEF_ADDR_STATUS);
  assign hit_raw = pef_addr_is(avs_address, PEF_ADDR_RAW);
  // Both flag views take write-one-to-clear; the raw view ignores writes
  assign clear_hit = lane0_write && (hit_flags || hit_status);
  assign mask_hit = lane0_write && hit_mask;
  assign mask_next = avs_writedata[7:0] & PEF_FLAG_IMPL;

  // Clear only by software write-one; hardware never self-clears
  always_comb begin
    clr = '0;
    if (clear_hit) begin
      clr = avs_writedata[PEF_NUM_EVENTS-1:0]; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flag cells: one per implemented flag, upper bits read zero

  genvar gi;
  generate
    for (gi = 0; gi < PEF_NUM_EVENTS; gi++) begin : g_flag
      pef_flag_cell u_cell (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set_evt(events[gi]),
        .clr_req(clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  assign flags_byte = pef_pad(flags);
  assign raw_byte = pef_pad(events);

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Captured in the request cycle; a flag set later shows on the next read
  always_comb begin
    read_word = PEF_UNMAPPED_READ;
    if (hit_flags) begin
      read_word = pef_widen(flags_byte);
    end else if (hit_mask) begin
      read_word = pef_widen(state.mask);
    end else if (hit_status) begin
      read_word = pef_widen(pending_byte);
    end else if (hit_raw) begin
      read_word = pef_widen(raw_byte);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt

  // Level output; stays high until software clears or masks the source
  assign pending_byte = flags_byte & state.mask;
  assign irq_next = |pending_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave

  always_comb begin
    next_state = state;
    next_state.waitreq = 1'b1;
    case (state.bus)
      PEF_BUS_IDLE: begin
        // One wait state gives registered read data
        if (any_request) begin
          next_state.bus = PEF_BUS_ACK;
          next_state.waitreq = 1'b0;
          next_state.rdata = read_word;
        end
      end
      PEF_BUS_ACK: begin
        // Master must drop the request at this edge
        next_state.bus = PEF_BUS_IDLE;
      end
      default: begin
        next_state.bus = PEF_BUS_IDLE;
      end
    endcase
    if (mask_hit) begin
      next_state.mask = mask_next;
    end
    if (take_read) begin
      next_state.rdata = state.rdata;
    end
    // Level irq, one cycle behind the flags
    next_state.irq = irq_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge rst_n) begin
    // Waitrequest held high in reset so no access is taken
    if (!rst_n) begin
      state.bus <= PEF_BUS_IDLE;
      state.mask <= PEF_MASK_RESET;
      state.rdata <= 32'h00000000;
      state.waitreq <= 1'b1;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = state.rdata;
  assign avs_waitrequest = state.waitreq;
  assign irq = state.irq;
endmodule

// ===== core/pef_flag_cell.sv
// Sticky flag cell: set by hardware event, cleared by writing one
module pef_flag_cell
  import pef_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic set_evt,
  input wire logic clr_req,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } pef_cell_state_t;

  pef_cell_state_t state;
  pef_cell_state_t next_state;

  always_comb begin
    next_state = state;
    // Set wins over a same-cycle clear so no event is lost
    if (set_evt) begin
      next_state.flag = 1'b1; // R7
    end else if (clr_req) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;
endmodule

// ===== core/pef_pkg.sv
// Package: register map, field positions and reset values of the event flag block
package pef_pkg;
  localparam logic [1:0] PEF_ADDR_FLAGS = 2'h0;
  localparam logic [1:0] PEF_ADDR_MASK = 2'h1;
  localparam logic [1:0] PEF_ADDR_STATUS = 2'h2;
  localparam logic [1:0] PEF_ADDR_RAW = 2'h3;
  localparam int PEF_BIT_GATE = 0;
  localparam int PEF_BIT_OVF = 1;
  localparam int PEF_BIT_VOLT = 2;
  localparam int PEF_BIT_COLA = 3;
  localparam int PEF_BIT_COLB = 4;
  localparam int PEF_NUM_EVENTS = 5;
  localparam logic [7:0] PEF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] PEF_MASK_RESET = 8'h00;
  localparam logic [7:0] PEF_FLAG_IMPL = 8'h1f;
  localparam logic [31:0] PEF_UNMAPPED_READ = 32'h00000000;
  typedef enum logic [1:0] {
    PEF_BUS_IDLE = 2'b00,
    PEF_BUS_ACK = 2'b01
  } pef_bus_state_t;
endpackage

// ===== test/pef_event_flags_sva.sv
// Checker: sticky flag assertions at the top ports
module pef_event_flags_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic port_b_collision,
  input wire logic port_a_collision,
  input wire logic voltage_low,
  input wire logic timer_c_counter_rollover,
  input wire logic timer_c_gate_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Flags read at the edge that ends the wait-state cycle, while waitrequest is still high
  wire rd0 = avs_read && avs_waitrequest && avs_address == 2'h0;
  property p_b; rd0 && $past(port_b_collision) |=> avs_readdata[4]; endproperty
  a_b: assert property (p_b) else $error("flag b lost");
  property p_a; rd0 && $past(port_a_collision) |=> avs_readdata[3]; endproperty
  a_a: assert property (p_a) else $error("flag a lost");
  property p_v; $past(voltage_low) ##0 rd0 |=> avs_readdata[2]; endproperty
  a_v: assert property (p_v) else $error("flag v lost");
  property p_o; rd0 && $past(timer_c_counter_rollover) |=> avs_readdata[1]; endproperty
  a_o: assert property (p_o) else $error("flag o lost");
  property p_g; rd0 && $past(timer_c_gate_event) |=> avs_readdata[0]; endproperty
  a_g: assert property (p_g) else $error("flag g lost");
  property p_w; avs_write && !avs_waitrequest && timer_c_gate_event ##1 rd0 |=> avs_readdata[0];
  endproperty
  a_w: assert property (p_w) else $error("set lost to clear");
endmodule
bind pef_event_flags pef_event_flags_sva i_sva (.*);

// ===== test/peripheral_event_flag_bits_bench.sv
// Bench: event flags driven and read over Avalon-MM
module peripheral_event_flag_bits_bench import pef_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
  logic [1:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [4:0] ev = 0;
  int error_cnt = 0, check_count = 0;
  pef_event_flags i_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
    .port_b_collision(ev[4]), .port_a_collision(ev[3]), .voltage_low(ev[2]),
    .timer_c_counter_rollover(ev[1]), .timer_c_gate_event(ev[0]));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Rel low keeps the bus busy so the next access follows back to back
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, bit rel = 1);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    if (rel) begin
      avs_read <= 0;
      avs_write <= 0;
      @(posedge sys_clk);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    rd(PEF_ADDR_FLAGS, 8'h00);
    rd(PEF_ADDR_MASK, 8'h00);
    for (int b = 0; b < 5; b++) begin
      ev <= 5'h1 << b;
      @(posedge sys_clk);
      ev <= 0;
      rd(PEF_ADDR_FLAGS, 8'h1 << b);
      rd(PEF_ADDR_FLAGS, 8'h1 << b);
      acc(1, PEF_ADDR_FLAGS, 8'h1 << b);
      rd(PEF_ADDR_FLAGS, 8'h00);
    end
    acc(1, PEF_ADDR_MASK, 8'h1f);
    ev <= 5'h04;
    @(posedge sys_clk);
    ev <= 0;
    repeat (2) @(posedge sys_clk);
    chk(irq, 1);
    rd(PEF_ADDR_STATUS, 8'h04);
    acc(1, PEF_ADDR_MASK, 8'h00);
    @(posedge sys_clk);
    chk(irq, 0);
    avs_byteenable <= 4'h0;
    acc(1, PEF_ADDR_FLAGS, 8'h1f);
    avs_byteenable <= 4'hf;
    rd(PEF_ADDR_FLAGS, 8'h04);
    acc(1, PEF_ADDR_FLAGS, 8'h1f);
    ev <= 5'h01;
    acc(1, PEF_ADDR_FLAGS, 8'h01, 0);
    ev <= 0;
    rd(PEF_ADDR_FLAGS, 8'h01);
    ev <= 5'h1a;
    rd(PEF_ADDR_RAW, 8'h1a);
    ev <= 0;
    acc(1, PEF_ADDR_STATUS, 8'h1f);
    rd(PEF_ADDR_FLAGS, 8'h00);
    acc(1, PEF_ADDR_MASK, 8'h1f);
    ev <= 5'h10;
    @(posedge sys_clk);
    ev <= 0;
    repeat (2) @(posedge sys_clk);
    chk(irq, 1);
    rst_n <= 0;
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    rst_n <= 1;
    @(posedge sys_clk);
    rd(PEF_ADDR_FLAGS, 8'h00);
    rd(PEF_ADDR_MASK, 8'h00);
    tally_and_finish;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
